// ### src/igce_pkg.sv
/*
 File holds the shared constants of the general-call response and enable
 status block: register offsets, field positions, reset values and the
 AHB-Lite encodings used by the register slave.
 Assumes one 32-bit AHB-Lite slave port and a 100 MHz core clock.
*/
package igce_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_GC_RESP = 8'h98;
   localparam logic [ADDR_W-1:0] OFF_EN_STATE = 8'h9c;
   localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h6c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'ha0;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'ha4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'ha8;
   localparam int GC_ACK_BIT = 0;
   localparam int EN_FLAG_BIT = 0;
   localparam int OFF_BUSY_BIT = 1;
   localparam int RX_LOST_BIT = 2;
   localparam int IRQ_W = 3;
   localparam int IRQ_DIS_DONE = 0;
   localparam int IRQ_ABORT = 1;
   localparam int IRQ_LOST = 2;
   localparam logic GC_ACK_RESET = 1'b1;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {
      IGCE_TGT_IDLE,
      IGCE_TGT_ADDR,
      IGCE_TGT_RX_DATA,
      IGCE_TGT_TX
   } igce_tgt_e;
endpackage

// ### src/igce_top.sv
/*
 File holds the general-call acknowledge selection and the enable status
 report of an I2C controller, with its AHB-Lite register slave.
 Assumes the byte-level target engine supplies one-cycle event pulses on
 the core clock, and that the bus engine reports when the controller may
 really go quiet after a disable request.
*/
// The implementer's own choice: the AHB-Lite interface to the registers.
// What this block does
// - With the select bit at one a General Call address is acknowledged by driving SDA low.
// - With the select bit at zero a General Call address is refused by leaving SDA released.
// - The select bit resets to one and is a read/write bit 0 of its register.
// - The select bit only matters while the controller acts as a target.
// - While enabled the status report shows bits 2:1 as zero and bit 0 as one.
// - After a disable, bits 2:1 are meaningful only once the enabled flag reads zero.
// - The enabled flag falls only after a delay governed by current bus activity.
// - Loss flag sets when a disable aborts a matched target receive after its data phase began.
// - Loss flag clears when disabled without taking part in a target-receive data phase.
// - Busy-abort flag sets when disabled during target address or receive data bytes.
// - Busy-abort means a not-acknowledge was forced, matched or not, also for a pending disable.
// - A STOP before the forced not-acknowledge with the enable cleared sets both flags.
// - Busy-abort clears when disabled while idle or while the controller acts as master.
// - Enabled flag mirrors the enabled port; all status bits read-only and reset to zero.
`timescale 1ns/1ps
module igce_top
   import igce_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [igce_pkg::ADDR_W-1:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic MASTER_MODE,
   input wire logic ADDR_BYTE_DONE,
   input wire logic [7:0] ADDR_BYTE,
   input wire logic ADDR_MATCH,
   input wire logic ACK_SLOT,
   input wire logic TARGET_ACTIVE,
   input wire logic RX_DATA_START,
   input wire logic STOP_SEEN,
   input wire logic BUS_QUIET,
   output logic GC_ACK_DRIVE,
   output logic FORCE_NACK,
   output logic ENABLED_PORT,
   output logic IRQ
);
   import igce_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave
   logic ph_valid;
   logic ph_write;
   logic [ADDR_W-1:0] ph_addr;
   logic wr_gc;
   logic wr_en;
   logic wr_clr;
   logic wr_irq_en;
   logic gc_ack_select;
   logic enable_ctrl;
   logic rx_lost;
   logic off_busy;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_en;
   logic [IRQ_W-1:0] irq_evt;
   logic [31:0] next_rdata;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= '0;
      end else if (HREADY) begin
         ph_valid <= HSEL && HTRANS == HTRANS_NONSEQ && HSIZE == HSIZE_WORD;
         ph_write <= HWRITE;
         ph_addr <= HADDR;
      end
   end

   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign wr_gc = ph_valid && ph_write && ph_addr == OFF_GC_RESP;
   assign wr_en = ph_valid && ph_write && ph_addr == OFF_ENABLE;
   assign wr_clr = ph_valid && ph_write && ph_addr == OFF_IRQ_CLR;
   assign wr_irq_en = ph_valid && ph_write && ph_addr == OFF_IRQ_EN;

   // Read data is formed from the address-phase address so it is ready next cycle.
   // The status word samples live state, so software must honour the settle rule.
   always_comb begin
      next_rdata = ZERO_WORD;
      case (HADDR)
         OFF_GC_RESP: next_rdata[GC_ACK_BIT] = gc_ack_select;
         OFF_EN_STATE: begin
            next_rdata[EN_FLAG_BIT] = ENABLED_PORT;
            next_rdata[OFF_BUSY_BIT] = off_busy;
            next_rdata[RX_LOST_BIT] = rx_lost;
         end
         OFF_ENABLE: next_rdata[0] = enable_ctrl;
         OFF_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
         OFF_IRQ_EN: next_rdata[IRQ_W-1:0] = irq_en;
         default: next_rdata = ZERO_WORD;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         HRDATA <= ZERO_WORD;
      end else if (HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE) begin
         HRDATA <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         gc_ack_select <= GC_ACK_RESET;
      end else if (wr_gc) begin
         gc_ack_select <= HWDATA[GC_ACK_BIT];
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         enable_ctrl <= 1'b0;
      end else if (wr_en) begin
         enable_ctrl <= HWDATA[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Target transfer tracking
   igce_tgt_e tgt_state;
   logic is_gen_call;
   logic in_rx_data;
   logic gc_pending;

   assign is_gen_call = ADDR_BYTE[7:1] == GEN_CALL_ADDR && !ADDR_BYTE[0];

   // Tracks how far a target transfer has gone, so that a disable can tell
   // an address byte from a data phase. Any STOP, a disabled port or master
   // operation returns it to idle.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tgt_state <= IGCE_TGT_IDLE;
      end else if (STOP_SEEN || !ENABLED_PORT || MASTER_MODE) begin
         tgt_state <= IGCE_TGT_IDLE;
      end else begin
         case (tgt_state)
            IGCE_TGT_IDLE: if (TARGET_ACTIVE) tgt_state <= IGCE_TGT_ADDR;
            IGCE_TGT_ADDR: begin
               if (ADDR_BYTE_DONE && ADDR_MATCH) begin
                  tgt_state <= ADDR_BYTE[0] ? IGCE_TGT_TX : IGCE_TGT_ADDR;
               end
               if (RX_DATA_START) tgt_state <= IGCE_TGT_RX_DATA;
            end
            IGCE_TGT_RX_DATA: tgt_state <= IGCE_TGT_RX_DATA;
            IGCE_TGT_TX: tgt_state <= IGCE_TGT_TX;
            default: tgt_state <= IGCE_TGT_IDLE;
         endcase
      end
   end

   assign in_rx_data = tgt_state == IGCE_TGT_RX_DATA;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         gc_pending <= 1'b0;
      end else if (ADDR_BYTE_DONE) begin
         gc_pending <= is_gen_call && !MASTER_MODE;
      end else if (STOP_SEEN || (gc_pending && ACK_SLOT)) begin
         gc_pending <= 1'b0;
      end
   end

   // Acknowledge only when selected, as a target, and still enabled
   assign GC_ACK_DRIVE = gc_pending && ACK_SLOT && gc_ack_select
      && enable_ctrl && !MASTER_MODE;

   ////////////////////////////////////////////////////////////////////////
   // Disable sequence and status flags
   logic dis_pending;
   logic busy_at_off;
   logic lost_at_off;

   assign busy_at_off = tgt_state == IGCE_TGT_ADDR || in_rx_data;
   assign lost_at_off = in_rx_data;

   // Enabled port rises at once and falls only after the bus goes quiet or a STOP is seen.
   // The pending flag holds it up for at least one more cycle, so a disable
   // never cuts a byte that is already on the wire.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ENABLED_PORT <= 1'b0;
         dis_pending <= 1'b0;
      end else if (enable_ctrl) begin
         ENABLED_PORT <= 1'b1;
         dis_pending <= 1'b0;
      end else if (ENABLED_PORT) begin
         dis_pending <= 1'b1;
         if (dis_pending && (BUS_QUIET || STOP_SEEN)) begin
            ENABLED_PORT <= 1'b0;
            dis_pending <= 1'b0;
         end
      end
   end

   // While disabling and busy the target refuses every byte
   assign FORCE_NACK = dis_pending && busy_at_off;

   // Flags are captured on the first cycle of a disable and may only grow
   // while the disable is pending; they freeze once the port has fallen,
   // which is when software may trust them.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         off_busy <= 1'b0;
         rx_lost <= 1'b0;
      end else if (enable_ctrl) begin
         off_busy <= 1'b0;
         rx_lost <= 1'b0;
      end else if (ENABLED_PORT && !dis_pending) begin
         off_busy <= busy_at_off;
         rx_lost <= lost_at_off;
      end else if (dis_pending && STOP_SEEN && busy_at_off) begin
         off_busy <= 1'b1;
         rx_lost <= 1'b1;
      end else if (dis_pending && busy_at_off) begin
         off_busy <= 1'b1;
         rx_lost <= rx_lost | lost_at_off;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts
   // Events fire on the fall of the enabled port, when the flags are final.
   logic en_q;
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         en_q <= 1'b0;
      end else begin
         en_q <= ENABLED_PORT;
      end
   end

   assign irq_evt[IRQ_DIS_DONE] = en_q && !ENABLED_PORT;
   assign irq_evt[IRQ_ABORT] = en_q && !ENABLED_PORT && off_busy;
   assign irq_evt[IRQ_LOST] = en_q && !ENABLED_PORT && rx_lost;

   // Set wins over a clear in the same cycle
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~(wr_clr ? HWDATA[IRQ_W-1:0] : '0)) | irq_evt;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_en <= '0;
      end else if (wr_irq_en) begin
         irq_en <= HWDATA[IRQ_W-1:0];
      end
   end

   assign IRQ = |(irq_stat & irq_en);

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   a_gc_ack_on: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      gc_pending && ACK_SLOT && gc_ack_select && enable_ctrl && !MASTER_MODE
      |-> GC_ACK_DRIVE) else $error("General call not acknowledged");
   a_gc_nack_off: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      !gc_ack_select |-> !GC_ACK_DRIVE) else $error("General call acked while refused");
   a_gc_reset_val: assert property (@(posedge REF_CLK)
      $rose(RSTN) |-> gc_ack_select) else $error("Select bit not one after reset");
   a_gc_master_off: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      MASTER_MODE |-> !GC_ACK_DRIVE) else $error("Acknowledge while master");
   a_enabled_clean: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      enable_ctrl |=> ENABLED_PORT && !off_busy && !rx_lost)
      else $error("Enabled status not clean");
   a_en_delay: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $fell(enable_ctrl) |=> ENABLED_PORT) else $error("Enabled flag fell at once");
   a_stop_both: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      dis_pending && STOP_SEEN && busy_at_off && !enable_ctrl |=> off_busy && rx_lost)
      else $error("Stop during disable did not set flags");
   a_idle_clear: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      ENABLED_PORT && !enable_ctrl && !dis_pending && tgt_state == IGCE_TGT_IDLE
      |=> !off_busy && !rx_lost) else $error("Idle disable left flags set");
   a_lost_implies: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $rose(rx_lost) |-> $past(busy_at_off)) else $error("Loss without receive");
   a_irq_level: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      IRQ == |(irq_stat & irq_en)) else $error("Interrupt level wrong");

   // Status bit 0 read back is the enabled port of the address phase
   a_status_mirror: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE && HADDR == OFF_EN_STATE
      |=> HRDATA[EN_FLAG_BIT] == $past(ENABLED_PORT))
      else $error("Status bit 0 does not mirror port");

   // A settled enable reads as enabled with both flags clear
   a_status_enabled: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE && HADDR == OFF_EN_STATE
      && enable_ctrl && $past(enable_ctrl)
      |=> HRDATA[EN_FLAG_BIT] && !HRDATA[OFF_BUSY_BIT] && !HRDATA[RX_LOST_BIT])
      else $error("Enabled status read wrong");

   // Out of reset every status bit is zero
   a_status_reset: assert property (@(posedge REF_CLK)
      $rose(RSTN) |-> !off_busy && !rx_lost && !ENABLED_PORT)
      else $error("Status not zero after reset");

   // The port only falls from a pending disable on a quiet bus or a STOP
   a_fall_cause: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $fell(ENABLED_PORT)
      |-> $past(dis_pending) && !$past(enable_ctrl) && ($past(BUS_QUIET) || $past(STOP_SEEN)))
      else $error("Enabled port fell without cause");

   // Once the port is down the flags no longer move
   a_flags_settled: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $fell(ENABLED_PORT) && !enable_ctrl
      |=> $stable(off_busy) && $stable(rx_lost))
      else $error("Flags moved after port fell");

   // Forced refusal only happens while the port is still up
   a_nack_when_up: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      FORCE_NACK |-> ENABLED_PORT)
      else $error("Forced refusal while inactive");

   // A busy target during a pending disable marks the busy-abort flag
   a_busy_marked: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      dis_pending && busy_at_off && !enable_ctrl
      |=> off_busy)
      else $error("Busy disable not flagged");

   // A disable outside a receive data phase captures the loss flag clear on its first cycle
   a_lost_clear: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      ENABLED_PORT && !enable_ctrl && !dis_pending && !in_rx_data
      |=> !rx_lost)
      else $error("Loss flag set outside data phase");

   // Any other address byte drops a pending general call
   a_gc_only_zero: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      ADDR_BYTE_DONE && !is_gen_call
      |=> !gc_pending)
      else $error("Non general call address kept pending");

   c_gc_ack: cover property (@(posedge REF_CLK) disable iff (!RSTN) GC_ACK_DRIVE);
   c_dis_busy: cover property (@(posedge REF_CLK) disable iff (!RSTN)
      $fell(ENABLED_PORT) && off_busy);
   c_dis_lost: cover property (@(posedge REF_CLK) disable iff (!RSTN)
      $fell(ENABLED_PORT) && rx_lost);
   c_dis_idle: cover property (@(posedge REF_CLK) disable iff (!RSTN)
      $fell(ENABLED_PORT) && !off_busy);
   // General call refused by the select bit
   c_gc_refused: cover property (@(posedge REF_CLK) disable iff (!RSTN)
      gc_pending && ACK_SLOT && !gc_ack_select && !MASTER_MODE);
endmodule

// ### tb/igce_remote_master.sv
/*
 Behavioural remote I2C master, seen through the event pulses of the
 target byte engine. Assumes one core clock shared with the block.
*/
`timescale 1ns/1ps
module igce_remote_master (
   input wire logic clk,
   output logic target_active,
   output logic addr_byte_done,
   output logic [7:0] addr_byte,
   output logic addr_match,
   output logic ack_slot,
   output logic rx_data_start,
   output logic stop_seen,
   output logic bus_quiet
);
   initial begin
      {target_active, addr_byte_done, addr_match, ack_slot} = 4'h0;
      {rx_data_start, stop_seen, addr_byte, bus_quiet} = {2'h0, 8'h5a, 1'b1};
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic begin_frame();
      @(posedge clk);
      target_active <= 1'b1;
      bus_quiet <= 1'b0;
      @(posedge clk);
      target_active <= 1'b0;
   endtask
   // Byte is only valid with its pulse; otherwise an inverted pattern
   task automatic send_addr(input logic [7:0] b, input logic m);
      begin_frame();
      addr_byte_done <= 1'b1;
      addr_byte <= b;
      addr_match <= m;
      @(posedge clk);
      addr_byte_done <= 1'b0;
      addr_byte <= ~b;
      addr_match <= 1'b0;
      ack_slot <= 1'b1;
   endtask
   task automatic end_ack();
      @(posedge clk);
      ack_slot <= 1'b0;
   endtask
   task automatic rx_data();
      @(posedge clk);
      rx_data_start <= 1'b1;
      @(posedge clk);
      rx_data_start <= 1'b0;
   endtask
   task automatic stop();
      @(posedge clk);
      stop_seen <= 1'b1;
      bus_quiet <= 1'b1;
      @(posedge clk);
      stop_seen <= 1'b0;
   endtask
endmodule

// ### tb/tb_top.sv
/*
 Self-checking bench of the general-call and enable status block.
 Assumes the zero-wait AHB-Lite slave and pulse events of the hand-over.
*/
`timescale 1ns/1ps
module tb_top;
   import igce_pkg::*;
   logic REF_CLK = 0, RSTN = 0, HSEL = 0, HWRITE = 0, MASTER_MODE = 0;
   logic [7:0] HADDR = 8'h0;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h0, HRDATA, d;
   logic HREADYOUT, GC_ACK_DRIVE, FORCE_NACK, ENABLED_PORT, IRQ, sel, mst;
   logic ta, abd, am, acks, rxs, stp, quiet;
   logic [7:0] ab, b;
   int errors = 0, samples_checked = 0, cycles = 0, seed;
   igce_top i_igce_top (.REF_CLK(REF_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(), .MASTER_MODE(MASTER_MODE),
      .ADDR_BYTE_DONE(abd), .ADDR_BYTE(ab), .ADDR_MATCH(am), .ACK_SLOT(acks),
      .TARGET_ACTIVE(ta), .RX_DATA_START(rxs), .STOP_SEEN(stp), .BUS_QUIET(quiet),
      .GC_ACK_DRIVE(GC_ACK_DRIVE), .FORCE_NACK(FORCE_NACK), .ENABLED_PORT(ENABLED_PORT),
      .IRQ(IRQ));
   igce_remote_master i_igce_remote_master (.clk(REF_CLK), .target_active(ta),
      .addr_byte_done(abd), .addr_byte(ab), .addr_match(am), .ack_slot(acks),
      .rx_data_start(rxs), .stop_seen(stp), .bus_quiet(quiet));
   initial forever #5 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("Error at %0t: timeout", $time);
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task stop_test();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function logic [31:0] exp_status(input logic en, input logic busy, input logic lost);
      return {29'h0, lost, busy, en};
   endfunction
   function logic exp_gc(input logic s, input logic [7:0] a, input logic m);
      return s && a == 8'h00 && !m;
   endfunction
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      HSEL <= 1'b1;
      HADDR <= a;
      HTRANS <= HTRANS_NONSEQ;
      HWRITE <= w;
      HSIZE <= HSIZE_WORD;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= wd;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   // Enable, disable in the given bus state, then read the settled status
   task dis_case(input int kind, input logic [31:0] expst);
      ahb(1'b1, OFF_ENABLE, 32'h1, d);
      repeat (3) @(posedge REF_CLK);
      ahb(1'b0, OFF_EN_STATE, ZERO_WORD, d);
      chk(d, exp_status(1'b1, 1'b0, 1'b0));
      if (kind == 1)
         i_igce_remote_master.begin_frame();
      if (kind == 2) begin
         i_igce_remote_master.send_addr(8'h42, 1'b1);
         i_igce_remote_master.end_ack();
         i_igce_remote_master.rx_data();
      end
      ahb(1'b1, OFF_ENABLE, ZERO_WORD, d);
      if (kind != 0) begin
         repeat (3) @(posedge REF_CLK);
         #1 chk(ENABLED_PORT, 32'h1);
         chk(FORCE_NACK, 32'h1);
         i_igce_remote_master.stop();
      end
      while (ENABLED_PORT !== 1'b0) @(posedge REF_CLK);
      ahb(1'b0, OFF_EN_STATE, ZERO_WORD, d);
      chk(d, expst);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(31);
      repeat (20) @(posedge REF_CLK);
      RSTN <= 1'b1;
      @(posedge REF_CLK);
      ahb(1'b0, OFF_GC_RESP, ZERO_WORD, d);
      chk(d, 32'h1);
      ahb(1'b1, OFF_EN_STATE, 32'h7, d);
      ahb(1'b0, OFF_EN_STATE, ZERO_WORD, d);
      chk(d, exp_status(1'b0, 1'b0, 1'b0));
      ahb(1'b0, 8'h40, ZERO_WORD, d);
      chk(d, ZERO_WORD);
      ahb(1'b1, OFF_ENABLE, 32'h1, d);
      for (int i = 0; i < 12; i++) begin
         sel = 1'($urandom);
         b = ($urandom % 2) ? 8'h00 : 8'($urandom);
         mst = 1'($urandom % 4 == 0);
         case (i)
            0: {sel, b, mst} = {1'b1, 8'h00, 1'b0};
            1: {sel, b, mst} = {1'b0, 8'h00, 1'b0};
            2: {sel, b, mst} = {1'b1, 8'h01, 1'b0};
            3: {sel, b, mst} = {1'b1, 8'h00, 1'b1};
            default: ;
         endcase
         MASTER_MODE <= mst;
         ahb(1'b1, OFF_GC_RESP, {31'h0, sel}, d);
         ahb(1'b0, OFF_GC_RESP, ZERO_WORD, d);
         chk(d, {31'h0, sel});
         i_igce_remote_master.send_addr(b, b == 8'h00);
         #1 chk(GC_ACK_DRIVE, exp_gc(sel, b, mst));
         i_igce_remote_master.end_ack();
         i_igce_remote_master.stop();
      end
      MASTER_MODE <= 1'b0;
      dis_case(0, exp_status(1'b0, 1'b0, 1'b0));
      dis_case(1, exp_status(1'b0, 1'b1, 1'b1));
      ahb(1'b1, OFF_IRQ_CLR, 32'h7, d);
      ahb(1'b1, OFF_IRQ_EN, 32'h7, d);
      dis_case(2, exp_status(1'b0, 1'b1, 1'b1));
      #1 chk(IRQ, 32'h1);
      ahb(1'b0, OFF_IRQ_STAT, ZERO_WORD, d);
      chk(d, 32'h7);
      ahb(1'b1, OFF_IRQ_CLR, 32'h7, d);
      ahb(1'b1, OFF_IRQ_EN, ZERO_WORD, d);
      #1 chk(IRQ, 32'h0);
      dis_case(0, exp_status(1'b0, 1'b0, 1'b0));
      #1 chk(IRQ, 32'h0);
      ahb(1'b0, OFF_IRQ_STAT, ZERO_WORD, d);
      chk(d, 32'h1);
      stop_test();
   end
endmodule
